/* File: pkg/mac_regs.svh */
`ifndef MAC_REGS_SVH
`define MAC_REGS_SVH
// Register byte offsets
`define OFS_TX_STATUS 12'h004
`define OFS_RX_CONFIG 12'h00C
`define OFS_COLL_COUNT 12'h010
`define OFS_RX_STATUS 12'h014
`define OFS_STATION_LO 12'h018
`define OFS_STATION_HI 12'h01C
`define OFS_MCAST_LO 12'h020
`define OFS_MCAST_HI 12'h024
`define OFS_TX_CTRL 12'h028
// Transmit status bit positions
`define TS_OK 0
`define TS_COL 2
`define TS_ABORT 3
`define TS_CRS 4
`define TS_UNDER 5
`define TS_HB 6
`define TS_LATE 7
// Receive configuration and status bit positions
`define RC_SEP 0
`define RC_AR 1
`define RC_AB 2
`define RC_AM 3
`define RC_PRO 4
`define RC_MON 5
`define RS_DIS 6
// Reset values
`define RX_CONFIG_RST 8'h00
// Attempt limit and frame sizes
`define MAX_ATTEMPTS 5'h10
`define MIN_FRAME 7'h40
`define MIN_RUNT 7'h08
// Timing in ns
`define HB_WINDOW_NS 6400
`define SLOT_NS 51200
`define CLK_NS 20
`endif

/* File: pkg/mac_pkg.sv */
package mac_pkg;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND = 2'b01,
    TX_HBEAT = 2'b11
  } tx_state_t;
endpackage : mac_pkg

/* File: pkg/rx_filter_if.sv */
interface rx_filter_if;
  logic [47:0] dest;
  logic [47:0] station;
  logic [63:0] mcast_hash;
  logic [5:0] hash_idx;
  logic [7:0] cfg;
  logic crc_err;
  logic align_err;
  logic [6:0] len;
  logic len_ge_min;
  logic accept;
  logic recognized;
  modport top (output dest, station, mcast_hash, hash_idx, cfg, crc_err, align_err, len, len_ge_min,
    input accept, recognized);
  modport filt (input dest, station, mcast_hash, hash_idx, cfg, crc_err, align_err, len, len_ge_min,
    output accept, recognized);
endinterface : rx_filter_if

/* File: core/rx_filter.sv */
`include "mac_regs.svh"
module rx_filter (
  rx_filter_if.filt f
);
  logic is_mcast;
  logic is_bcast;
  logic addr_ok;
  logic err_ok;
  logic len_ok;
  always_comb begin
    is_bcast = &f.dest;
    is_mcast = f.dest[0] & ~is_bcast;
    addr_ok = 1'b0;
    if (is_bcast) begin
      addr_ok = f.cfg[`RC_AB];
    end else if (is_mcast) begin
      addr_ok = f.cfg[`RC_AM] & f.mcast_hash[f.hash_idx];
    end else begin
      addr_ok = f.cfg[`RC_PRO] | (f.dest == f.station);
    end
    err_ok = f.cfg[`RC_SEP] | ~(f.crc_err | f.align_err);
    len_ok = f.len_ge_min | (f.cfg[`RC_AR] & (f.len >= `MIN_RUNT));
  end
  assign f.recognized = addr_ok & err_ok & len_ok;
  assign f.accept = f.recognized & ~f.cfg[`RC_MON];
endmodule : rx_filter

/* File: core/mac_tx_status_rx_filter.sv */
// Notes on behaviour
// - New transmission clears all transmit flags.
// - Flags set only by events during transmit.
// - OK flag only without abort/underrun.
// - Collided flag; collisions counted separately.
// - Abort and flag at sixteen attempts.
// - Carrier loss flagged, transmission continues.
// - Underrun flags and aborts packet.
// - Heartbeat missing in window flags failure.
// - Late collision flagged, retried normally.
// - Status undefined before first transmission.
// - Errored packets accepted only when enabled.
// - Runts of 8+ bytes accepted when enabled.
// - Broadcast accepted only when enabled.
// - Multicast accepted when hash bit set.
// - Promiscuous or exact station match.
// - Monitor checks, counts, never buffers.
// - Acceptance enables do not combine: each address type checks its own; PRO covers only physical addresses.
// - Disabled flag follows monitor operation.
//
// Implementation choice: the APB slave port.
`include "mac_regs.svh"
module mac_tx_status_rx_filter #(
  parameter int HB_CYCLES = (`HB_WINDOW_NS) / (`CLK_NS),
  parameter int SLOT_CYCLES = (`SLOT_NS) / (`CLK_NS)
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_collision,
  input wire logic tx_carrier,
  input wire logic tx_fifo_empty,
  input wire logic tx_bus_granted,
  input wire logic tx_done,
  output logic tx_active,
  output logic tx_abort,
  output logic tx_retry,
  input wire logic rx_frame_end,
  input wire logic [47:0] rx_dest,
  input wire logic [5:0] rx_hash_idx,
  input wire logic rx_crc_err,
  input wire logic rx_align_err,
  input wire logic [10:0] rx_len,
  output logic rx_buffer,
  output logic rx_missed
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [3:0] pin_s1_reg;
  logic [3:0] pin_s2_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= 4'h0;
      pin_s2_reg <= 4'h0;
    end else begin
      pin_s1_reg <= {tx_collision, tx_carrier, tx_done, rx_frame_end};
      pin_s2_reg <= pin_s1_reg;
    end
  end
  logic coll_s;
  logic carrier_s;
  logic done_s;
  logic rxend_s;
  assign {coll_s, carrier_s, done_s, rxend_s} = pin_s2_reg;
  logic coll_d_reg;
  logic rxend_d_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      coll_d_reg <= 1'b0;
      rxend_d_reg <= 1'b0;
    end else begin
      coll_d_reg <= coll_s;
      rxend_d_reg <= rxend_s;
    end
  end
  logic coll_rise;
  logic rxend_rise;
  // Edge flops reset to the idle pin level so no false edge follows reset
  assign coll_rise = coll_s & ~coll_d_reg;
  assign rxend_rise = rxend_s & ~rxend_d_reg;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit
  logic wr_en;
  logic rd_en;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign pready = 1'b1;
  logic mapped;
  assign mapped = hit(paddr, `OFS_TX_STATUS) | hit(paddr, `OFS_RX_CONFIG) | hit(paddr, `OFS_COLL_COUNT)
    | hit(paddr, `OFS_RX_STATUS) | hit(paddr, `OFS_STATION_LO) | hit(paddr, `OFS_STATION_HI)
    | hit(paddr, `OFS_MCAST_LO) | hit(paddr, `OFS_MCAST_HI) | hit(paddr, `OFS_TX_CTRL);
  assign pslverr = psel & penable & ~mapped;

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [7:0] rx_config_reg;
  logic [47:0] station_reg;
  logic [63:0] mcast_hash_reg;
  logic tx_start;
  assign tx_start = wr_en & hit(paddr, `OFS_TX_CTRL) & pwdata[0];
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_config_reg <= `RX_CONFIG_RST;
      station_reg <= 48'h0;
      mcast_hash_reg <= 64'h0;
    end else if (wr_en) begin
      if (hit(paddr, `OFS_RX_CONFIG)) begin
        rx_config_reg <= {2'b00, pwdata[5:0]};
      end
      if (hit(paddr, `OFS_STATION_LO)) begin
        station_reg[31:0] <= pwdata;
      end
      if (hit(paddr, `OFS_STATION_HI)) begin
        station_reg[47:32] <= pwdata[15:0];
      end
      if (hit(paddr, `OFS_MCAST_LO)) begin
        mcast_hash_reg[31:0] <= pwdata;
      end
      if (hit(paddr, `OFS_MCAST_HI)) begin
        mcast_hash_reg[63:32] <= pwdata;
      end
    end
  end

  // ----------------------------------------
  // Transmit sequencer
  // ----------------------------------------
  mac_pkg::tx_state_t tx_state_reg;
  logic [4:0] attempts_reg;
  logic [15:0] tx_timer_reg;
  logic [7:0] tx_status_reg;
  logic [4:0] collision_count_reg;
  logic abort_now;
  logic underrun_now;
  logic attempt_fail;

  // Underrun wins over an excessive collision in the same cycle
  assign underrun_now = tx_fifo_empty & ~tx_bus_granted;
  assign attempt_fail = coll_rise & (attempts_reg + 5'h01 >= `MAX_ATTEMPTS);
  assign abort_now = (tx_state_reg == mac_pkg::TX_SEND) & (underrun_now | attempt_fail);
  assign tx_active = (tx_state_reg == mac_pkg::TX_SEND);
  assign tx_abort = abort_now;
  assign tx_retry = (tx_state_reg == mac_pkg::TX_SEND) & coll_rise & ~attempt_fail & ~underrun_now;


  // Timer saturates so a very long frame cannot wrap into a false slot time
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_reg <= mac_pkg::TX_IDLE;
      attempts_reg <= 5'h00;
      tx_timer_reg <= 16'h0000;
    end else begin
      unique case (tx_state_reg)
        mac_pkg::TX_IDLE: begin
          if (tx_start) begin
            tx_state_reg <= mac_pkg::TX_SEND;
            attempts_reg <= 5'h00;
            tx_timer_reg <= 16'h0000;
          end
        end
        mac_pkg::TX_SEND: begin
          if (abort_now) begin
            tx_state_reg <= mac_pkg::TX_IDLE;
          end else if (coll_rise) begin
            attempts_reg <= attempts_reg + 5'h01;
            tx_timer_reg <= 16'h0000;
          end else if (done_s) begin
            tx_state_reg <= mac_pkg::TX_HBEAT;
            tx_timer_reg <= 16'h0000;
          end else if (tx_timer_reg != 16'hFFFF) begin
            tx_timer_reg <= tx_timer_reg + 16'h0001;
          end
        end
        mac_pkg::TX_HBEAT: begin
          if (coll_s || tx_timer_reg >= 16'(HB_CYCLES - 1)) begin
            tx_state_reg <= mac_pkg::TX_IDLE;
          end else begin
            tx_timer_reg <= tx_timer_reg + 16'h0001;
          end
        end
        default: begin
          tx_state_reg <= mac_pkg::TX_IDLE;
        end
      endcase
    end
  end


  // ----------------------------------------
  // Transmit status and collision count
  // ----------------------------------------
  // Set and clear never meet: clearing is done only in idle, setting only while busy

  // Status register is zero after reset although software must not rely on it
  // undefined before first transmit
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_status_reg <= 8'h00;
      collision_count_reg <= 5'h00;
    end else if (tx_state_reg == mac_pkg::TX_IDLE) begin
      if (tx_start) begin
        tx_status_reg <= 8'h00;
        collision_count_reg <= 5'h00;
      end
    end else if (tx_state_reg == mac_pkg::TX_SEND) begin
      if (coll_rise) begin
        tx_status_reg[`TS_COL] <= 1'b1;
        collision_count_reg <= collision_count_reg + 5'h01;
        if (tx_timer_reg >= 16'(SLOT_CYCLES)) begin
          tx_status_reg[`TS_LATE] <= 1'b1;
        end
      end
      if (!carrier_s) begin
        tx_status_reg[`TS_CRS] <= 1'b1;
      end
      if (underrun_now) begin
        tx_status_reg[`TS_UNDER] <= 1'b1;
      end
      if (attempt_fail && !underrun_now) begin
        tx_status_reg[`TS_ABORT] <= 1'b1;
      end
      if (done_s && !abort_now && !coll_rise) begin
        tx_status_reg[`TS_OK] <= 1'b1;
      end
    end else begin
      if (!coll_s && tx_timer_reg >= 16'(HB_CYCLES - 1)) begin
        tx_status_reg[`TS_HB] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Receive filter
  // ----------------------------------------
  rx_filter_if fif ();
  assign fif.dest = rx_dest;
  assign fif.station = station_reg;
  assign fif.mcast_hash = mcast_hash_reg;
  assign fif.hash_idx = rx_hash_idx;
  assign fif.cfg = rx_config_reg;
  assign fif.crc_err = rx_crc_err;
  assign fif.align_err = rx_align_err;
  assign fif.len = (rx_len >= 11'(`MIN_FRAME)) ? `MIN_FRAME : rx_len[6:0];
  assign fif.len_ge_min = rx_len >= 11'(`MIN_FRAME);
  rx_filter u_filter (
    .f(fif.filt)
  );


  // ----------------------------------------
  // Receive verdict
  // ----------------------------------------
  // Verdicts are one-cycle pulses so a downstream counter sees each frame once

  logic rx_disabled_flag;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_buffer <= 1'b0;
      rx_missed <= 1'b0;
      rx_disabled_flag <= 1'b0;
    end else begin
      // Frame-end qualifies the verdict; inputs are assumed stable by then
      rx_buffer <= rxend_rise & fif.accept;
      rx_missed <= rxend_rise & fif.recognized & rx_config_reg[`RC_MON];
      rx_disabled_flag <= rx_config_reg[`RC_MON];
    end
  end


  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Data is captured in the setup cycle so the zero-wait access phase
  // can return it from a flop; write-only and unmapped offsets read zero

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      if (hit(paddr, `OFS_TX_STATUS)) begin
        prdata <= {24'h000000, tx_status_reg};
      end
      if (hit(paddr, `OFS_COLL_COUNT)) begin
        prdata <= {27'h0000000, collision_count_reg};
      end
      if (hit(paddr, `OFS_RX_STATUS)) begin
        prdata <= {25'h0000000, rx_disabled_flag, 6'h00};
      end
      if (hit(paddr, `OFS_STATION_LO)) begin
        prdata <= station_reg[31:0];
      end
      if (hit(paddr, `OFS_STATION_HI)) begin
        prdata <= {16'h0000, station_reg[47:32]};
      end
      if (hit(paddr, `OFS_MCAST_LO)) begin
        prdata <= mcast_hash_reg[31:0];
      end
      if (hit(paddr, `OFS_MCAST_HI)) begin
        prdata <= mcast_hash_reg[63:32];
      end
      if (hit(paddr, `OFS_TX_CTRL)) begin
        prdata <= {31'h00000000, tx_active};
      end
    end
  end

  // Read strobe kept for symmetry with the write path; the capture above
  // already happens in the setup cycle
  logic unused_rd;
  assign unused_rd = rd_en;

endmodule : mac_tx_status_rx_filter

/* File: sim/apb_host.sv */
module apb_host (
  input wire logic core_clk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // -----------------------------
  // Host bus cycle
  // -----------------------------
  // status read back
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Slave latency is its own business, so no cycle count is assumed
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : apb_host

/* File: sim/mac_tx_status_rx_filter_assertions.sv */
module mac_tx_status_rx_filter_chk #(
  parameter int HB_CYCLES = 320,
  parameter int SLOT_CYCLES = 2560
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_active,
  input wire logic tx_abort,
  input wire logic tx_retry,
  input wire logic rx_frame_end,
  input wire logic rx_buffer,
  input wire logic rx_missed
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // -----------------------------
  // Checks
  // -----------------------------
  chk_start_sends: assert property (
    psel && penable && pwrite && paddr == 12'h028 && pwdata[0] && !tx_active |=> tx_active)
    else $error("start ignored");
  chk_abort_ends: assert property (
    tx_abort |-> tx_active ##1 !tx_active) else $error("abort kept sending");
  chk_retry_keeps: assert property (
    tx_retry |-> tx_active ##1 tx_active) else $error("retry stopped sending");
  chk_retry_abort: assert property (
    tx_retry |-> !tx_abort) else $error("retry with abort");
  chk_rx_exclusive: assert property (
    rx_missed |-> !rx_buffer) else $error("monitor packet buffered");
  chk_rx_cause: assert property (
    rx_buffer || rx_missed |-> $past(rx_frame_end, 3) || $past(rx_frame_end, 4) || $past(rx_frame_end, 5))
    else $error("verdict without frame");
  chk_buffer_pulse: assert property (
    rx_buffer |=> !rx_buffer) else $error("buffer pulse too long");
  chk_missed_pulse: assert property (
    rx_missed |=> !rx_missed) else $error("missed pulse too long");
  chk_ready_high: assert property (pready) else $error("ready low");
  chk_err_unmapped: assert property (
    psel && penable && paddr == 12'h0FC |-> pslverr) else $error("no error on hole");
  cover property (tx_abort);
  cover property (tx_retry);
  cover property (rx_missed);
endmodule : mac_tx_status_rx_filter_chk

bind mac_tx_status_rx_filter mac_tx_status_rx_filter_chk #(
  .HB_CYCLES(HB_CYCLES),
  .SLOT_CYCLES(SLOT_CYCLES)
) chk_u (
  .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .tx_active, .tx_abort, .tx_retry, .rx_frame_end, .rx_buffer, .rx_missed
);

/* File: sim/mac_tx_status_rx_filter_bench.sv */
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin bad_count++; $display("ERROR %s exp %0h got %0h", n, e, s); end end
module mac_tx_status_rx_filter_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [47:0] ST = 48'h1122_3344_5566;
  localparam logic [47:0] OT = 48'h0000_0000_0002;
  localparam logic [47:0] BC = 48'hFFFF_FFFF_FFFF;
  localparam logic [47:0] MC = 48'h0000_0000_0001;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic tx_collision = 1'b0, tx_carrier = 1'b1, tx_fifo_empty = 1'b0, tx_bus_granted = 1'b1, tx_done = 1'b0;
  logic tx_active, tx_abort, tx_retry, rx_buffer, rx_missed;
  logic rx_frame_end = 1'b0, rx_crc_err = 1'b0, rx_align_err = 1'b0;
  logic [47:0] rx_dest = 48'h0;
  logic [5:0] rx_hash_idx = 6'h00;
  logic [10:0] rx_len = 11'h040;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #10 core_clk = ~core_clk;
  mac_tx_status_rx_filter #(.HB_CYCLES(8), .SLOT_CYCLES(32)) dut_u (
    .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .tx_collision, .tx_carrier, .tx_fifo_empty, .tx_bus_granted, .tx_done, .tx_active, .tx_abort,
    .tx_retry, .rx_frame_end, .rx_dest, .rx_hash_idx, .rx_crc_err, .rx_align_err, .rx_len,
    .rx_buffer, .rx_missed
  );
  apb_host host_u (.core_clk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite, .paddr, .pwdata);
  // -----------------------------
  // Helpers
  // -----------------------------
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, q, perr);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
    host_u.xfer(1'b0, a, 32'h0, q, perr);
    `CHK(n, e, q & m)
  endtask : rd
  task automatic col;
    @(posedge core_clk) tx_collision <= 1'b1;
    cyc(3);
    tx_collision <= 1'b0;
    cyc(4);
  endtask : col
  // Heartbeat pulse lands inside the shortened window
  task automatic end_tx(input logic hb);
    @(posedge core_clk) tx_done <= 1'b1;
    cyc(3);
    tx_done <= 1'b0;
    if (hb) col();
    cyc(25);
  endtask : end_tx
  task automatic frame(input logic [7:0] c, input logic [47:0] d, input logic [5:0] h, input logic [1:0] er,
    input logic [10:0] n, input logic [1:0] e);
    logic [1:0] seen;
    seen = 2'b00;
    wr(12'h00C, {24'h0, c});
    @(posedge core_clk) rx_dest <= d;
    rx_hash_idx <= h;
    {rx_align_err, rx_crc_err} <= er;
    rx_len <= n;
    @(posedge core_clk) rx_frame_end <= 1'b1;
    cyc(2);
    rx_frame_end <= 1'b0;
    repeat (8) begin
      @(posedge core_clk);
      seen = seen | {rx_missed, rx_buffer};
    end
    `CHK("verdict", e, seen)
  endtask : frame
  // -----------------------------
  // Scenarios
  // -----------------------------
  task automatic t_tx_ok;
    wr(12'h028, 32'h1);
    cyc(1);
    `CHK("active", 1'b1, tx_active)
    col();
    end_tx(1'b1);
    rd(12'h004, 32'hFF, 32'h05, "status");
    rd(12'h010, 32'h1F, 32'h01, "count");
    $display("t_tx_ok done");
  endtask : t_tx_ok
  task automatic t_tx_events;
    wr(12'h028, 32'h1);
    rd(12'h004, 32'hFF, 32'h00, "cleared");
    rd(12'h010, 32'h1F, 32'h00, "count clr");
    @(posedge core_clk) tx_carrier <= 1'b0;
    cyc(4);
    tx_carrier <= 1'b1;
    cyc(4);
    `CHK("keeps on", 1'b1, tx_active)
    cyc(32);
    col();
    `CHK("resched", 1'b1, tx_active)
    end_tx(1'b0);
    rd(12'h004, 32'hFF, 32'hD5, "events");
    $display("t_tx_events done");
  endtask : t_tx_events
  task automatic t_tx_abort;
    wr(12'h028, 32'h1);
    repeat (15) col();
    `CHK("15 tries", 1'b1, tx_active)
    col();
    `CHK("aborted", 1'b0, tx_active)
    cyc(25);
    rd(12'h004, 32'h3F, 32'h0C, "abort");
    wr(12'h028, 32'h1);
    @(posedge core_clk) tx_fifo_empty <= 1'b1;
    tx_bus_granted <= 1'b0;
    cyc(2);
    tx_fifo_empty <= 1'b0;
    tx_bus_granted <= 1'b1;
    `CHK("underrun", 1'b0, tx_active)
    cyc(25);
    rd(12'h004, 32'h3F, 32'h20, "under");
    $display("t_tx_abort done");
  endtask : t_tx_abort
  task automatic t_rx;
    wr(12'h018, 32'h3344_5566);
    wr(12'h01C, 32'h0000_1122);
    wr(12'h020, 32'h0000_0020);
    wr(12'h024, 32'h0);
    frame(8'h00, ST, 6'h00, 2'b00, 11'h040, 2'b01);
    frame(8'h00, OT, 6'h00, 2'b00, 11'h040, 2'b00);
    frame(8'h10, OT, 6'h00, 2'b00, 11'h040, 2'b01);
    frame(8'h00, BC, 6'h00, 2'b00, 11'h040, 2'b00);
    frame(8'h04, BC, 6'h00, 2'b00, 11'h040, 2'b01);
    frame(8'h08, MC, 6'h05, 2'b00, 11'h040, 2'b01);
    frame(8'h08, MC, 6'h06, 2'b00, 11'h040, 2'b00);
    frame(8'h0C, ST, 6'h00, 2'b00, 11'h040, 2'b01);
    frame(8'h00, ST, 6'h00, 2'b11, 11'h040, 2'b00);
    frame(8'h01, ST, 6'h00, 2'b01, 11'h040, 2'b01);
    frame(8'h00, ST, 6'h00, 2'b00, 11'h03F, 2'b00);
    frame(8'h02, ST, 6'h00, 2'b00, 11'h008, 2'b01);
    frame(8'h02, ST, 6'h00, 2'b00, 11'h007, 2'b00);
    // Full promiscuous setup: all three enables plus an all-ones hash
    wr(12'h020, 32'hFFFF_FFFF);
    wr(12'h024, 32'hFFFF_FFFF);
    frame(8'h1C, MC, 6'h06, 2'b00, 11'h040, 2'b01);
    frame(8'h1C, OT, 6'h00, 2'b00, 11'h040, 2'b01);
    frame(8'h20, ST, 6'h00, 2'b00, 11'h040, 2'b10);
    rd(12'h014, 32'h40, 32'h40, "disabled");
    wr(12'h00C, 32'h0);
    rd(12'h014, 32'h40, 32'h00, "enabled");
    rd(12'h00C, 32'hFF, 32'h00, "write only");
    rd(12'h0FC, 32'hFFFF_FFFF, 32'h0, "hole");
    `CHK("slverr", 1'b1, perr)
    $display("t_rx done");
  endtask : t_rx
  initial begin
    cyc(10);
    rst_n <= 1'b1;
    t_tx_ok();
    t_tx_events();
    t_tx_abort();
    t_rx();
    end_sim();
  end
endmodule : mac_tx_status_rx_filter_bench
